//--- logic/wss_top.sv
// Waveform steering and auto-shutdown core with register port
`timescale 1ns/10ps
module wss_top (
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	input  wire logic              fast_clk_ok,
	input  wire wss_pkg::wss_bus_t bus,
	output logic [7:0]             rdata,
	input  wire wss_pkg::wss_src_t src,
	input  wire logic [4:0]        shutdown_src,
	output wss_pkg::wss_pins_t     pins,
	output logic                   generator_clock_code,
	output logic                   irq
);
	import wss_pkg::*;

	// ------------------------------------------------
	// Registers
	// ------------------------------------------------
	logic [7:0] ctrl0_reg;
	logic [7:0] ctrl1_reg;
	logic [7:0] clk_reg;
	logic [7:0] dat_reg;
	logic [7:0] str_reg;
	logic [3:0] steer_act_reg;
	logic [7:0] as0_reg;
	logic       shut_reg;
	logic       hold_reg;
	logic [7:0] as1_reg;
	logic [7:0] istat_reg;
	logic [7:0] ien_reg;
	logic [7:0] rdata_next;
	logic [3:0] out_reg;
	logic [3:0] oe_reg;

	logic       data_in;
	logic       data_rise;
	logic       src_active;
	logic       wr_ctrl0;
	logic       wr_str;
	logic       wr_as0;
	logic       sw_clear;
	logic       sw_set;
	logic       hw_clear;
	logic       steer_mode;
	logic [2:0] mode;
	logic [3:0] pol;
	logic [1:0] lvl_bd;
	logic [1:0] lvl_ac;
	logic [3:0] out_next;
	logic [3:0] oe_next;
	logic [7:0] ev;

	// Masked register write helper: unimplemented bits stay zero
	function automatic logic [7:0] wss_mask(input logic [7:0] v,
		input logic [7:0] m);
		wss_mask = v & m;
	endfunction

	// Shutdown level for one output
	function automatic logic [1:0] wss_shut_pin(input logic [1:0] lvl,
		input logic p);
		logic [1:0] r;
		r = 2'b01;
		unique case (lvl)
			WSS_LVL_HIGH:     r = 2'b11;
			WSS_LVL_LOW:      r = 2'b01;
			WSS_LVL_TRI:      r = 2'b00;
			WSS_LVL_INACTIVE: r = {p, 1'b1};
		endcase
		wss_shut_pin = r;
	endfunction

	// ------------------------------------------------
	// Source selection
	// ------------------------------------------------
	wss_source_mux u_mux (
		.sys_clk          (sys_clk),
		.rst_n            (rst_n),
		.src              (src),
		.data_source_code (dat_reg[3:0]),
		.data_in          (data_in),
		.data_rise        (data_rise)
	);

	// Decodes
	assign mode       = ctrl0_reg[2:0];
	assign pol        = ctrl1_reg[3:0];
	assign lvl_bd     = as0_reg[5:4];
	assign lvl_ac     = as0_reg[3:2];
	assign steer_mode = (mode == WSS_MODE_ASYNC)
		| (mode == WSS_MODE_SYNC);
	assign src_active = |(shutdown_src & as1_reg[4:0]);
	assign wr_ctrl0   = bus.wr & (bus.addr == WSS_OFS_CTRL0);
	assign wr_str     = bus.wr & (bus.addr == WSS_OFS_STR);
	assign wr_as0     = bus.wr & (bus.addr == WSS_OFS_AS0);
	assign sw_set     = wr_as0 & bus.wdata[WSS_BIT_SHUT]
		& ~ctrl0_reg[WSS_BIT_EN];
	// Refused while any enabled source still asserts
	assign sw_clear   = wr_as0 & ~bus.wdata[WSS_BIT_SHUT]
		& ~src_active;
	assign hw_clear   = as0_reg[WSS_BIT_REN] & ~src_active;

	// Clock code goes to the clock tree; fast oscillator only if present
	assign generator_clock_code = clk_reg[0] & fast_clk_ok;

	// ------------------------------------------------
	// Plain configuration registers
	// ------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ctrl0_reg <= WSS_ZERO8;
			ctrl1_reg <= WSS_ZERO8;
			clk_reg   <= WSS_ZERO8;
			dat_reg   <= WSS_ZERO8;
			as1_reg   <= WSS_ZERO8;
			ien_reg   <= WSS_ZERO8;
		end else if (bus.wr) begin
			unique case (bus.addr)
				WSS_OFS_CTRL0: ctrl0_reg <= wss_mask(bus.wdata,
					WSS_MASK_CTRL0);
				WSS_OFS_CTRL1: ctrl1_reg <= wss_mask(bus.wdata,
					WSS_MASK_CTRL1);
				WSS_OFS_CLK:   clk_reg <= wss_mask(bus.wdata,
					WSS_MASK_CLK);
				WSS_OFS_DAT:   dat_reg <= wss_mask(bus.wdata,
					WSS_MASK_DAT);
				WSS_OFS_AS1:   as1_reg <= wss_mask(bus.wdata,
					WSS_MASK_AS1);
				WSS_OFS_IEN:   ien_reg <= wss_mask(bus.wdata,
					WSS_MASK_IRQ);
				default: ;
			endcase
		end
	end

	// ------------------------------------------------
	// Steering register and its active copy
	// ------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			str_reg <= WSS_ZERO8;
		end else if (wr_str) begin
			str_reg <= bus.wdata;
		end
	end

	// Sync mode waits for a data rising edge so no output glitches mid-cycle
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			steer_act_reg <= 4'h0;
		end else if (mode == WSS_MODE_SYNC) begin
			if (data_rise) begin
				steer_act_reg <= str_reg[3:0];
			end
		end else begin
			steer_act_reg <= str_reg[3:0];
		end
	end

	// ------------------------------------------------
	// Shutdown configuration and status
	// ------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			as0_reg <= WSS_RST_AS0;
		end else if (wr_as0) begin
			as0_reg <= wss_mask(bus.wdata, WSS_MASK_AS0CFG);
		end
	end

	// Set beats every clear, so an arriving event is never lost
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			shut_reg <= 1'b0;
		end else if (src_active | sw_set) begin
			shut_reg <= 1'b1;
		end else if (sw_clear | hw_clear) begin
			shut_reg <= 1'b0;
		end
	end

	// Outputs hold shutdown levels until the data input next rises
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			hold_reg <= 1'b0;
		end else if (shut_reg) begin
			hold_reg <= 1'b1;
		end else if (data_rise) begin
			hold_reg <= 1'b0;
		end
	end

	// ------------------------------------------------
	// Output steering and override
	// ------------------------------------------------
	always_comb begin
		logic [1:0] pa;
		pa       = 2'b00;
		out_next = 4'h0;
		oe_next  = 4'h0;
		for (int i = 0; i < 4; i++) begin
			if (shut_reg | hold_reg) begin
				// A,C use the A/C field; B,D the B/D field
				pa = wss_shut_pin((i % 2 == 0) ? lvl_ac : lvl_bd,
					pol[i]);
				out_next[i] = pa[1];
				oe_next[i]  = pa[0];
			end else if (!ctrl0_reg[WSS_BIT_EN]) begin
				out_next[i] = pol[i];
				oe_next[i]  = 1'b1;
			end else if (steer_mode) begin
				out_next[i] = steer_act_reg[i]
					? (data_in ^ pol[i])
					: str_reg[4 + i];
				oe_next[i]  = 1'b1;
			end else begin
				// Bridge modes live elsewhere; idle inactive here
				out_next[i] = pol[i];
				oe_next[i]  = 1'b1;
			end
		end
	end

	// Pins come from flip-flops: one cycle of latency, no glitches
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			out_reg <= 4'h0;
			oe_reg  <= 4'h0;
		end else begin
			out_reg <= out_next;
			oe_reg  <= oe_next;
		end
	end

	assign pins.out = out_reg;
	assign pins.oe  = oe_reg;

	// ------------------------------------------------
	// Interrupt status: shutdown entry and resume
	// ------------------------------------------------
	assign ev = {6'h00, hold_reg & ~shut_reg & data_rise,
		(src_active | sw_set) & ~shut_reg};

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			istat_reg <= WSS_ZERO8;
		end else if (bus.wr && bus.addr == WSS_OFS_ICLR) begin
			istat_reg <= (istat_reg & ~bus.wdata) | ev;
		end else begin
			istat_reg <= istat_reg | ev;
		end
	end

	assign irq = |(istat_reg & ien_reg);

	// ------------------------------------------------
	// Read port, data one cycle after the strobe
	// ------------------------------------------------
	always_comb begin
		rdata_next = WSS_ZERO8;
		unique case (bus.addr)
			WSS_OFS_CTRL0: rdata_next = ctrl0_reg;
			WSS_OFS_CTRL1: rdata_next = ctrl1_reg
				| (8'(data_in) << WSS_BIT_IN);
			WSS_OFS_CLK:   rdata_next = clk_reg;
			WSS_OFS_DAT:   rdata_next = dat_reg;
			WSS_OFS_STR:   rdata_next = str_reg;
			WSS_OFS_AS0:   rdata_next = as0_reg
				| (8'(shut_reg) << WSS_BIT_SHUT);
			WSS_OFS_AS1:   rdata_next = as1_reg;
			WSS_OFS_ISTAT: rdata_next = istat_reg;
			WSS_OFS_IEN:   rdata_next = ien_reg;
			default:       rdata_next = WSS_ZERO8;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rdata <= WSS_ZERO8;
		end else if (bus.rd) begin
			rdata <= rdata_next;
		end else begin
			rdata <= WSS_ZERO8;
		end
	end

endmodule

//--- logic/wss_pkg.sv
// Package: register map, field layout and types of the waveform steering block
//
// Notes on behaviour
// - Clock select 0 system, 1 fast oscillator
// - Four-bit code picks data input; 1110-1111 reserved
// - Steered output carries data, polarity applied
// - Unsteered output drives its override level
// - Steering controls act only in modes 00x
// - Synchronous mode double-buffers steering enables
// - Bit 7 shows shutdown in effect
// - Restart enable picks automatic restart
// - B/D shutdown field forces B and D
// - A/C shutdown field forces A and C
// - Shutdown bit writable while module disabled
// - Shutdown levels hold until data rising edge
// - Unimplemented bits ignore writes, read zero
// - Software clear refused while source active
// - Auto-restart clears shutdown when sources gone
// - Mode 001 synchronous, 000 asynchronous steering
package wss_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [3:0] WSS_OFS_CTRL0 = 4'h0;
	localparam logic [3:0] WSS_OFS_CTRL1 = 4'h1;
	localparam logic [3:0] WSS_OFS_CLK   = 4'h2;
	localparam logic [3:0] WSS_OFS_DAT   = 4'h3;
	localparam logic [3:0] WSS_OFS_STR   = 4'h4;
	localparam logic [3:0] WSS_OFS_AS0   = 4'h5;
	localparam logic [3:0] WSS_OFS_AS1   = 4'h6;
	localparam logic [3:0] WSS_OFS_ISTAT = 4'h7;
	localparam logic [3:0] WSS_OFS_IEN   = 4'h8;
	localparam logic [3:0] WSS_OFS_ICLR  = 4'h9;

	// ----------------------------------------
	// Field positions and masks
	// ----------------------------------------
	localparam int         WSS_BIT_EN       = 7;
	localparam int         WSS_BIT_SHUT     = 7;
	localparam int         WSS_BIT_REN      = 6;
	localparam int         WSS_BIT_IN       = 5;
	localparam logic [7:0] WSS_MASK_CTRL0   = 8'h87;
	localparam logic [7:0] WSS_MASK_CTRL1   = 8'h0f;
	localparam logic [7:0] WSS_MASK_CLK     = 8'h01;
	localparam logic [7:0] WSS_MASK_DAT     = 8'h0f;
	localparam logic [7:0] WSS_MASK_AS0CFG  = 8'h7c;
	localparam logic [7:0] WSS_MASK_AS1     = 8'h1f;
	localparam logic [7:0] WSS_MASK_IRQ     = 8'h03;
	localparam logic [7:0] WSS_RST_AS0      = 8'h14;
	localparam logic [7:0] WSS_ZERO8        = 8'h00;

	// ----------------------------------------
	// Codes
	// ----------------------------------------
	localparam logic [2:0] WSS_MODE_ASYNC   = 3'h0;
	localparam logic [2:0] WSS_MODE_SYNC    = 3'h1;
	localparam logic [1:0] WSS_LVL_INACTIVE = 2'h0;
	localparam logic [1:0] WSS_LVL_TRI      = 2'h1;
	localparam logic [1:0] WSS_LVL_LOW      = 2'h2;
	localparam logic [1:0] WSS_LVL_HIGH     = 2'h3;
	localparam logic [3:0] WSS_DAT_LAST     = 4'hd;
	localparam int         WSS_IRQ_SHUT     = 0;
	localparam int         WSS_IRQ_RESUME   = 1;

	// Bus request bundle
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} wss_bus_t;

	// Data-source candidates, index = source code
	typedef struct packed {
		logic [3:0] logic_cell;
		logic       numeric_osc;
		logic [1:0] pulse_unit;
		logic [3:0] capture_unit;
		logic       comparator_two_output;
		logic       comparator_one_output;
		logic       pin_assigned_input;
	} wss_src_t;

	// Output pin bundle, index 0..3 = A..D
	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe;
	} wss_pins_t;

endpackage

//--- logic/wss_source_mux.sv
// Data-source selector with rising-edge detect on the chosen waveform
`timescale 1ns/10ps
module wss_source_mux (
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	input  wire wss_pkg::wss_src_t src,
	input  wire logic [3:0]       data_source_code,
	output logic                  data_in,
	output logic                  data_rise
);
	import wss_pkg::*;

	logic [13:0] src_vec;
	logic        sel;
	logic        prev_reg;

	// Reserved codes select a quiet low input
	assign src_vec = src;
	always_comb begin
		if (data_source_code <= WSS_DAT_LAST) begin
			sel = src_vec[data_source_code];
		end else begin
			sel = 1'b0;
		end
	end

	// Data input is taken as synchronous; edge found against last sample
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			prev_reg <= 1'b0;
		end else begin
			prev_reg <= sel;
		end
	end

	assign data_in   = sel;
	assign data_rise = sel & ~prev_reg;

endmodule

//--- testbench/wss_assertions.sv
// Checker for the steering core ports
`timescale 1ns/10ps
module wss_checker (
	input wire logic               sys_clk,
	input wire logic               rst_n,
	input wire logic               fast_clk_ok,
	input wire wss_pkg::wss_bus_t  bus,
	input wire logic [7:0]         rdata,
	input wire logic [4:0]         shutdown_src,
	input wire wss_pkg::wss_pins_t pins,
	input wire logic               generator_clock_code
);
	import wss_pkg::*;
	logic [7:0] shut_cfg_reg;
	logic [4:0] src_en_reg;
	logic       src_on;

	// Shadow of the shutdown setup; status is left to the core
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			shut_cfg_reg <= WSS_RST_AS0;
			src_en_reg <= 5'h00;
		end else if (bus.wr && bus.addr == WSS_OFS_AS0) begin
			shut_cfg_reg <= bus.wdata & WSS_MASK_AS0CFG;
		end else if (bus.wr && bus.addr == WSS_OFS_AS1) begin
			src_en_reg <= bus.wdata[4:0];
		end
	end
	assign src_on = |(shutdown_src & src_en_reg);

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// ----
	// Properties
	// ----
	// Three cycles of source: status set, then pins registered
	sequence s_held;
		(src_on && !(bus.wr && bus.addr == WSS_OFS_AS0))[*3];
	endsequence
	sequence s_clr_try;
		src_on ##1 (src_on && bus.wr && bus.addr == WSS_OFS_AS0
			&& !bus.wdata[WSS_BIT_SHUT]);
	endsequence

	AST_RD_IDLE: assert property (!$past(bus.rd) |->
		rdata == WSS_ZERO8) else $error("stray read data");
	AST_CLK_SEL: assert property (generator_clock_code |->
		fast_clk_ok) else $error("fast clock used while absent");
	AST_CLK_ZERO: assert property (
		bus.rd && bus.addr == WSS_OFS_CLK |=> rdata[7:1] == 7'h00)
		else $error("clock select upper bits set");
	AST_DAT_ZERO: assert property (
		bus.rd && bus.addr == WSS_OFS_DAT |=> rdata[7:4] == 4'h0)
		else $error("source code upper bits set");
	AST_SHUT_ZERO: assert property (
		bus.rd && bus.addr == WSS_OFS_AS0 |=> rdata[1:0] == 2'h0)
		else $error("shutdown low bits set");
	AST_SHUT_SET: assert property (src_on[*2] ##0
		(bus.rd && bus.addr == WSS_OFS_AS0) |=> rdata[WSS_BIT_SHUT])
		else $error("shutdown status not set");
	AST_REFUSE: assert property (s_clr_try ##1
		(src_on && bus.rd && bus.addr == WSS_OFS_AS0)
		|=> rdata[WSS_BIT_SHUT])
		else $error("shutdown cleared while source active");
	AST_LVL_AC: assert property (s_held ##0 shut_cfg_reg[3] |->
		pins.out[0] == shut_cfg_reg[2]
		&& pins.out[2] == shut_cfg_reg[2]
		&& pins.oe[0] && pins.oe[2])
		else $error("A/C shutdown level wrong");
	AST_LVL_BD: assert property (s_held ##0 shut_cfg_reg[5] |->
		pins.out[1] == shut_cfg_reg[4]
		&& pins.out[3] == shut_cfg_reg[4]
		&& pins.oe[1] && pins.oe[3])
		else $error("B/D shutdown level wrong");
	AST_LVL_TRI: assert property (s_held ##0
		shut_cfg_reg[5:4] == WSS_LVL_TRI |-> !pins.oe[1] && !pins.oe[3])
		else $error("B/D not released");
endmodule

bind wss_top wss_checker i_chk (
	.sys_clk(sys_clk), .rst_n(rst_n), .fast_clk_ok(fast_clk_ok),
	.bus(bus), .rdata(rdata), .shutdown_src(shutdown_src), .pins(pins),
	.generator_clock_code(generator_clock_code)
);

//--- testbench/wss_power_stage.sv
// Power stage model: gate-drive inputs of the switches
`timescale 1ns/10ps
module wss_power_stage (
	input wire wss_pkg::wss_pins_t pins,
	output logic [3:0]             gate
);
	import wss_pkg::*;
	// Released pin sinks through the gate pull-down, never floats
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			gate[i] = pins.oe[i] ? pins.out[i] : 1'b0;
		end
	end
endmodule

//--- testbench/tb.sv
// Testbench for the steering and shutdown core
`timescale 1ns/10ps
module tb;
	import wss_pkg::*;
	logic       sys_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       fast_clk_ok = 1'b0;
	wss_bus_t   bus = '0;
	wss_src_t   src = '0;
	logic [4:0] shutdown_src = 5'h00;
	logic [7:0] rdata;
	wss_pins_t  pins;
	logic       generator_clock_code;
	logic       irq;
	logic [3:0] gate;
	logic [7:0] rv;
	logic [7:0] rows [8][3];
	int         n_fail = 0;
	int         compares = 0;

	wss_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
		.fast_clk_ok(fast_clk_ok), .bus(bus), .rdata(rdata), .src(src),
		.shutdown_src(shutdown_src), .pins(pins), .irq(irq),
		.generator_clock_code(generator_clock_code));
	wss_power_stage i_stage (.pins(pins), .gate(gate));

	always #2 sys_clk = ~sys_clk;

	// ----
	// Helpers
	// ----
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Write, then read back at once so the refusal cannot hide
	task automatic wrrd(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus.rd <= 1'b0;
		#1 rv = rdata;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus.rd <= 1'b0;
		#1 rv = rdata;
	endtask
	// Pins settle within a few cycles; expected is {out, oe}
	task automatic pin_chk(input logic [7:0] exp);
		repeat (4) @(posedge sys_clk);
		#1 chk(pins, exp);
	endtask
	task automatic set_src(input logic [13:0] s);
		@(posedge sys_clk);
		src <= wss_src_t'(s);
	endtask
	task automatic stop_test();
		$display("Compares %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Hang guard, far beyond the expected run
	initial begin
		#20000;
		n_fail++;
		stop_test();
	end

	// ----
	// Main sequence
	// ----
	initial begin
		rows = '{'{8'h02, 8'hff, 8'h01}, '{8'h01, 8'hff, 8'h0f},
			'{8'h03, 8'hff, 8'h0f}, '{8'h04, 8'ha5, 8'ha5},
			'{8'h06, 8'hff, 8'h1f}, '{8'h08, 8'hff, 8'h03},
			'{8'h0a, 8'hff, 8'h00}, '{8'h00, 8'h7f, 8'h07}};
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(WSS_OFS_AS0);
		chk(rv, WSS_RST_AS0);
		for (int i = 0; i < 8; i++) begin
			wrrd(rows[i][0][3:0], rows[i][1]);
			chk(rv, rows[i][2]);
		end
		chk(8'(generator_clock_code), 8'h00);
		@(posedge sys_clk);
		fast_clk_ok <= 1'b1;
		@(posedge sys_clk);
		#1 chk(8'(generator_clock_code), 8'h01);
		// Every source code; reserved codes stay low with all sources up
		for (int c = 0; c < 16; c++) begin
			set_src((c < 14) ? (14'h0001 << c) : 14'h3fff);
			wrrd(WSS_OFS_DAT, 8'(c));
			rd(WSS_OFS_CTRL1);
			chk(8'(rv[WSS_BIT_IN]), 8'(c < 14));
		end
		wrrd(WSS_OFS_AS1, 8'h02);
		wrrd(WSS_OFS_CTRL1, 8'h02);
		wrrd(WSS_OFS_DAT, 8'h01);
		wrrd(WSS_OFS_STR, 8'ha3);
		wrrd(WSS_OFS_CTRL0, 8'h80);
		set_src(14'h0002);
		pin_chk(8'h9f);
		set_src(14'h0000);
		pin_chk(8'haf);
		wrrd(WSS_OFS_CTRL0, 8'h82);
		pin_chk(8'h2f);
		wrrd(WSS_OFS_CTRL0, 8'h81);
		wrrd(WSS_OFS_STR, 8'h0c);
		pin_chk(8'h2f);
		set_src(14'h0002);
		pin_chk(8'hcf);
		// Manual restart, B/D high and A/C low
		wrrd(WSS_OFS_AS0, 8'h38);
		@(posedge sys_clk);
		shutdown_src <= 5'h02;
		pin_chk(8'haf);
		chk(8'(irq), 8'h01);
		wrrd(WSS_OFS_AS0, 8'h38);
		chk(rv, 8'hb8);
		@(posedge sys_clk);
		shutdown_src <= 5'h00;
		wrrd(WSS_OFS_AS0, 8'h38);
		chk(rv, 8'h38);
		pin_chk(8'haf);
		set_src(14'h0000);
		repeat (3) @(posedge sys_clk);
		set_src(14'h0002);
		pin_chk(8'hcf);
		rd(WSS_OFS_ISTAT);
		chk(rv, 8'h03);
		wrrd(WSS_OFS_ICLR, 8'h03);
		rd(WSS_OFS_ISTAT);
		chk(rv, 8'h00);
		chk(8'(irq), 8'h00);
		// Auto restart with released pins and the interrupt masked
		wrrd(WSS_OFS_IEN, 8'h00);
		wrrd(WSS_OFS_AS0, 8'h54);
		@(posedge sys_clk);
		shutdown_src <= 5'h02;
		repeat (4) @(posedge sys_clk);
		#1 chk({gate, pins.oe}, 8'h00);
		chk(8'(irq), 8'h00);
		@(posedge sys_clk);
		shutdown_src <= 5'h00;
		rd(WSS_OFS_AS0);
		chk(rv, 8'h54);
		rd(WSS_OFS_ISTAT);
		chk(rv, 8'h01);
		// Software shutdown while disabled; a data edge frees pins first
		wrrd(WSS_OFS_AS0, 8'h38);
		set_src(14'h0000);
		set_src(14'h0002);
		wrrd(WSS_OFS_CTRL0, 8'h00);
		pin_chk(8'h2f);
		wrrd(WSS_OFS_AS0, 8'hb8);
		chk(rv, 8'hb8);
		pin_chk(8'haf);
		// Inactive level is the polarity level, not the live waveform
		wrrd(WSS_OFS_CTRL0, 8'h80);
		wrrd(WSS_OFS_AS0, 8'h80);
		chk(rv, 8'h80);
		pin_chk(8'h2f);
		stop_test();
	end
endmodule
